/* File: design/arith_cmd_pkg.sv */
`default_nettype none

package arith_cmd_pkg;

    // Frame geometry
    localparam int          BYTE_W        = 8;
    localparam int          WORD_W        = 32;
    localparam int          VAR_COUNT     = 256;
    localparam logic [3:0]  LAST_BYTE_IDX = 4'h8;
    localparam logic [3:0]  STAT_BYTE_IDX = 4'h2;
    localparam logic [3:0]  INSTR_BYTE_IDX = 4'h3;
    localparam logic [3:0]  TGT_BYTE_IDX  = 4'h1;
    localparam logic [3:0]  HOST_BYTE_IDX = 4'h0;
    localparam logic [3:0]  IDX_STEP      = 4'h1;
    localparam logic [7:0]  SUM_INIT      = 8'h00;

    // Addresses
    localparam logic [7:0]  DEF_MODULE_ADDR = 8'h01;
    localparam logic [7:0]  DEF_HOST_ADDR   = 8'h02;

    // Instruction codes
    localparam logic [7:0]  VAR_FROM_ACC_CALC  = 8'h29;
    localparam logic [7:0]  ACC_FROM_VAR_CALC  = 8'h2a;
    localparam logic [7:0]  VAR_FROM_XREG_CALC = 8'h2b;

    // Reply status codes
    localparam logic [7:0]  STATUS_OK        = 8'h64;
    localparam logic [7:0]  STATUS_BAD_INSTR = 8'h02;
    localparam logic [7:0]  STATUS_BAD_TYPE  = 8'h03;

    // Operation selectors carried in the type byte
    localparam logic [7:0]  OP_ADD      = 8'h00;
    localparam logic [7:0]  OP_SUB      = 8'h01;
    localparam logic [7:0]  multiply_op = 8'h02;
    localparam logic [7:0]  OP_DIV      = 8'h03;
    localparam logic [7:0]  remainder_op = 8'h04;
    localparam logic [7:0]  OP_AND      = 8'h05;
    localparam logic [7:0]  OP_OR       = 8'h06;
    localparam logic [7:0]  OP_XOR      = 8'h07;
    localparam logic [7:0]  OP_NOT      = 8'h08;
    localparam logic [7:0]  OP_LOAD     = 8'h09;
    localparam logic [7:0]  OP_SWAP     = 8'h0a;
    localparam logic [7:0]  OP_COMPARE  = 8'h0b;

    // Command frame minus checksum, first received byte on top
    typedef struct packed {
        logic [7:0]        addr;
        logic [7:0]        instr;
        logic [7:0]        op;
        logic [7:0]        bank;
        logic [WORD_W-1:0] value;
    } cmd_frame_type;

    localparam int CMD_BITS = $bits(cmd_frame_type);

    // One byte on the serial byte stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_beat_type;

    // Compare outcome
    typedef struct packed {
        logic eq;
        logic lt;
    } cmp_flags_type;

    // Calculation outcome
    typedef struct packed {
        logic [WORD_W-1:0] target;
        logic [WORD_W-1:0] operand;
        logic              wr_target;
        logic              wr_operand;
        logic              cmp_valid;
        cmp_flags_type     flags;
        logic              op_ok;
    } calc_result_type;

endpackage

`default_nettype wire

/* File: design/calc_unit.sv */
`default_nettype none

module calc_unit (
    // Operation select and operands
    input  wire logic [7:0]                       op,
    input  wire logic [arith_cmd_pkg::WORD_W-1:0] target_val,
    input  wire logic [arith_cmd_pkg::WORD_W-1:0] operand_val,
    // Outcome
    output arith_cmd_pkg::calc_result_type        result
);
    import arith_cmd_pkg::*;

    // Target is the register being modified, operand the second input
    always_comb begin
        result            = '0;
        result.target     = target_val;
        result.operand    = operand_val;
        result.op_ok      = 1'b1;
        result.wr_target  = 1'b1;
        case (op)
            OP_ADD:       result.target = target_val + operand_val;
            OP_SUB:       result.target = target_val - operand_val;
            multiply_op:  result.target = target_val * operand_val;
            // Division by zero yields zero rather than hanging
            OP_DIV: begin
                if (operand_val == '0) begin
                    result.target = '0;
                end else begin
                    result.target = WORD_W'($signed(target_val)
                                            / $signed(operand_val));
                end
            end
            remainder_op: begin
                if (operand_val == '0) begin
                    result.target = '0;
                end else begin
                    result.target = WORD_W'($signed(target_val)
                                            % $signed(operand_val));
                end
            end
            OP_AND:       result.target = target_val & operand_val;
            OP_OR:        result.target = target_val | operand_val;
            OP_XOR:       result.target = target_val ^ operand_val;
            OP_NOT:       result.target = ~operand_val;
            OP_LOAD:      result.target = operand_val;
            OP_SWAP: begin
                result.target     = operand_val;
                result.operand    = target_val;
                result.wr_operand = 1'b1;
            end
            // Compare only updates the flags
            OP_COMPARE: begin
                result.wr_target = 1'b0;
                result.cmp_valid = 1'b1;
                result.flags.eq  = target_val == operand_val;
                result.flags.lt  = $signed(target_val) < $signed(operand_val);
            end
            default: begin
                result.wr_target = 1'b0;
                result.op_ok     = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: design/variable_register_arith_cmds.sv */
// Contract
// - Code 42: accumulator op variable, result into accumulator.
// - Bank byte indexes variable 0..255; value field is ignored.
// - Accumulator ops 0..4: add, subtract, multiply, divide, modulo.
// - Accumulator ops 5..7: AND, OR, XOR with variable into accumulator.
// - Accumulator ops 8..11: inverse, copy, swap, compare with variable.
// - Code 43 combines variable with X register, result back into variable.
// - Variable ops 0..7 use X register as second operand.
// - Variable ops 8..11: inverted X, copy X, swap, compare.
// - Executed command replies status 100; reply value has no meaning.
// - Reply: host, target, 64h, instruction, value MSB first, checksum.
// - Code 29h selects variable-from-accumulator, echoed in reply.
// - Code 41 combines variable with accumulator, result into variable.
`default_nettype none

module variable_register_arith_cmds #(
    parameter logic [7:0] MODULE_ADDR = arith_cmd_pkg::DEF_MODULE_ADDR,
    parameter logic [7:0] HOST_ADDR   = arith_cmd_pkg::DEF_HOST_ADDR
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              reset_n,
    // Command byte stream from host
    input  wire arith_cmd_pkg::byte_beat_type      rx_beat,
    // Reply byte stream to host
    input  wire logic                              tx_ready,
    output arith_cmd_pkg::byte_beat_type           tx_beat,
    // Register state
    output logic [arith_cmd_pkg::WORD_W-1:0]       acc_value,
    output logic [arith_cmd_pkg::WORD_W-1:0]       xreg_value,
    output arith_cmd_pkg::cmp_flags_type           cmp_flags,
    // Side loading of registers and variables
    input  wire logic                              acc_load_en,
    input  wire logic [arith_cmd_pkg::WORD_W-1:0]  acc_load_data,
    input  wire logic                              xreg_load_en,
    input  wire logic [arith_cmd_pkg::WORD_W-1:0]  xreg_load_data,
    input  wire logic                              var_load_en,
    input  wire logic [7:0]                        var_load_index,
    input  wire logic [arith_cmd_pkg::WORD_W-1:0]  var_load_data,
    // Variable observation
    input  wire logic [7:0]                        var_peek_index,
    output logic [arith_cmd_pkg::WORD_W-1:0]       var_peek_data
);
    import arith_cmd_pkg::*;

    typedef enum logic [1:0] {ST_RECV, ST_EXEC, ST_SEND} state_type;

    state_type         state_q,  state_d;
    logic [3:0]        idx_q,    idx_d;
    logic [7:0]        sum_q,    sum_d;
    logic [7:0]        status_q, status_d;
    cmd_frame_type     cmd_q,    cmd_d;
    byte_beat_type     tx_q,     tx_d;
    logic [WORD_W-1:0] acc_q,    acc_d;
    logic [WORD_W-1:0] xreg_q,   xreg_d;
    logic [WORD_W-1:0] peek_q,   peek_d;
    cmp_flags_type     flags_q,  flags_d;
    logic [WORD_W-1:0] var_mem [VAR_COUNT];
    logic [WORD_W-1:0] var_rd;
    logic              var_we;
    logic [7:0]        var_widx;
    logic [WORD_W-1:0] var_wdata;
    logic [WORD_W-1:0] calc_a;
    logic [WORD_W-1:0] calc_b;
    logic              instr_known;
    logic              exec_ok;
    calc_result_type   res;

    // Modulo-256 running checksum
    function automatic logic [7:0] csum_add(input logic [7:0] sum,
                                            input logic [7:0] data);
        csum_add = sum + data;
    endfunction

    // Reply byte by position; value bytes are always zero
    function automatic logic [7:0] reply_byte(input logic [3:0] idx,
                                              input logic [7:0] status,
                                              input logic [7:0] instr,
                                              input logic [7:0] sum);
        case (idx)
            HOST_BYTE_IDX:  reply_byte = HOST_ADDR;
            TGT_BYTE_IDX:   reply_byte = MODULE_ADDR;
            STAT_BYTE_IDX:  reply_byte = status;
            INSTR_BYTE_IDX: reply_byte = instr;
            LAST_BYTE_IDX:  reply_byte = sum;
            default:        reply_byte = SUM_INIT;
        endcase
    endfunction

    // Value field never reaches the datapath; only bank indexes
    assign var_rd      = var_mem[cmd_q.bank];
    assign instr_known = cmd_q.instr == VAR_FROM_ACC_CALC
                      || cmd_q.instr == ACC_FROM_VAR_CALC
                      || cmd_q.instr == VAR_FROM_XREG_CALC;
    assign exec_ok     = state_q == ST_EXEC && instr_known && res.op_ok;

    // Pick target and second operand per instruction
    always_comb begin
        calc_a = acc_q;
        calc_b = var_rd;
        case (cmd_q.instr)
            VAR_FROM_ACC_CALC: begin
                calc_a = var_rd;
                calc_b = acc_q;
            end
            VAR_FROM_XREG_CALC: begin
                calc_a = var_rd;
                calc_b = xreg_q;
            end
            default: begin
                calc_a = acc_q;
                calc_b = var_rd;
            end
        endcase
    end

    calc_unit u_calc (
        .op          (cmd_q.op),
        .target_val  (calc_a),
        .operand_val (calc_b),
        .result      (res)
    );

    // Frame receive, execute handoff and reply sequencing
    always_comb begin
        state_d  = state_q;
        idx_d    = idx_q;
        sum_d    = sum_q;
        status_d = status_q;
        cmd_d    = cmd_q;
        tx_d     = tx_q;
        case (state_q)
            // Bytes arriving outside this state are dropped
            ST_RECV: begin
                if (rx_beat.valid) begin
                    if (idx_q == LAST_BYTE_IDX) begin
                        idx_d = '0;
                        sum_d = SUM_INIT;
                        if (rx_beat.data == sum_q
                            && cmd_q.addr == MODULE_ADDR) begin
                            state_d = ST_EXEC;
                        end
                    end else begin
                        idx_d = 4'(idx_q + IDX_STEP);
                        sum_d = csum_add(sum_q, rx_beat.data);
                        cmd_d = cmd_frame_type'(
                            {cmd_q[CMD_BITS-BYTE_W-1:0], rx_beat.data});
                    end
                end
            end
            ST_EXEC: begin
                if (!instr_known) begin
                    status_d = STATUS_BAD_INSTR;
                end else if (!res.op_ok) begin
                    status_d = STATUS_BAD_TYPE;
                end else begin
                    status_d = STATUS_OK;
                end
                tx_d.valid = 1'b1;
                tx_d.data  = reply_byte(HOST_BYTE_IDX, status_d,
                                        cmd_q.instr, sum_q);
                state_d    = ST_SEND;
            end
            ST_SEND: begin
                if (tx_q.valid && tx_ready) begin
                    sum_d = csum_add(sum_q, tx_q.data);
                    if (idx_q == LAST_BYTE_IDX) begin
                        idx_d   = '0;
                        sum_d   = SUM_INIT;
                        tx_d    = '0;
                        state_d = ST_RECV;
                    end else begin
                        idx_d     = 4'(idx_q + IDX_STEP);
                        // Instruction echoed at its slot
                        tx_d.data = reply_byte(idx_d, status_q,
                                               cmd_q.instr, sum_d);
                    end
                end
            end
            default: state_d = ST_RECV;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= ST_RECV;
            idx_q    <= '0;
            sum_q    <= SUM_INIT;
            status_q <= STATUS_OK;
            cmd_q    <= '0;
            tx_q     <= '0;
        end else begin
            state_q  <= state_d;
            idx_q    <= idx_d;
            sum_q    <= sum_d;
            status_q <= status_d;
            cmd_q    <= cmd_d;
            tx_q     <= tx_d;
        end
    end

    // Register updates; execution wins over side loads in its cycle
    always_comb begin
        acc_d     = acc_load_en  ? acc_load_data  : acc_q;
        xreg_d    = xreg_load_en ? xreg_load_data : xreg_q;
        flags_d   = flags_q;
        var_we    = var_load_en;
        var_widx  = var_load_index;
        var_wdata = var_load_data;
        peek_d    = var_mem[var_peek_index];
        if (exec_ok) begin
            if (res.cmp_valid) begin
                flags_d = res.flags;
            end
            case (cmd_q.instr)
                ACC_FROM_VAR_CALC: begin
                    if (res.wr_target) begin
                        acc_d = res.target;
                    end
                    var_we    = res.wr_operand;
                    var_widx  = cmd_q.bank;
                    var_wdata = res.operand;
                end
                default: begin
                    var_we    = res.wr_target;
                    var_widx  = cmd_q.bank;
                    var_wdata = res.target;
                    if (res.wr_operand
                        && cmd_q.instr == VAR_FROM_XREG_CALC) begin
                        xreg_d = res.operand;
                    end else if (res.wr_operand) begin
                        acc_d = res.operand;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q   <= '0;
            xreg_q  <= '0;
            flags_q <= '0;
            peek_q  <= '0;
        end else begin
            acc_q   <= acc_d;
            xreg_q  <= xreg_d;
            flags_q <= flags_d;
            peek_q  <= peek_d;
        end
    end

    // Variables carry no reset: clearing 256 words would cost a sweep
    always_ff @(posedge ref_clk) begin
        if (var_we) begin
            var_mem[var_widx] <= var_wdata;
        end
    end

    assign tx_beat       = tx_q;
    assign acc_value     = acc_q;
    assign xreg_value    = xreg_q;
    assign cmp_flags     = flags_q;
    assign var_peek_data = peek_q;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_acc_add;
        state_q == ST_EXEC && cmd_q.instr == ACC_FROM_VAR_CALC
            && cmd_q.op == OP_ADD
        |=> acc_q == $past(acc_q) + $past(var_rd);
    endproperty
    a_acc_add: assert property (p_acc_add)
        else $error("accumulator add wrong");

    property p_acc_div;
        state_q == ST_EXEC && cmd_q.instr == ACC_FROM_VAR_CALC
            && cmd_q.op == OP_DIV && var_rd != '0
        |=> acc_q == WORD_W'($signed($past(acc_q)) / $signed($past(var_rd)));
    endproperty
    a_acc_div: assert property (p_acc_div)
        else $error("accumulator divide wrong");

    property p_acc_xor;
        state_q == ST_EXEC && cmd_q.instr == ACC_FROM_VAR_CALC
            && cmd_q.op == OP_XOR
        |=> acc_q == ($past(acc_q) ^ $past(var_rd));
    endproperty
    a_acc_xor: assert property (p_acc_xor)
        else $error("accumulator xor wrong");

    property p_acc_swap;
        state_q == ST_EXEC && cmd_q.instr == ACC_FROM_VAR_CALC
            && cmd_q.op == OP_SWAP
        |-> (var_we && var_wdata == acc_q) ##1 acc_q == $past(var_rd);
    endproperty
    a_acc_swap: assert property (p_acc_swap)
        else $error("accumulator swap wrong");

    property p_var_sub_x;
        state_q == ST_EXEC && cmd_q.instr == VAR_FROM_XREG_CALC
            && cmd_q.op == OP_SUB
        |-> var_we && var_widx == cmd_q.bank && var_wdata == var_rd - xreg_q;
    endproperty
    a_var_sub_x: assert property (p_var_sub_x)
        else $error("variable minus X wrong");

    property p_var_not_x;
        state_q == ST_EXEC && cmd_q.instr == VAR_FROM_XREG_CALC
            && cmd_q.op == OP_NOT
        |-> var_we && var_wdata == ~xreg_q;
    endproperty
    a_var_not_x: assert property (p_var_not_x)
        else $error("variable not X wrong");

    property p_var_load_acc;
        state_q == ST_EXEC && cmd_q.instr == VAR_FROM_ACC_CALC
            && cmd_q.op == OP_LOAD
        |-> var_we && var_widx == cmd_q.bank && var_wdata == acc_q;
    endproperty
    a_var_load_acc: assert property (p_var_load_acc)
        else $error("variable load accumulator wrong");

    property p_status_ok;
        exec_ok |=> tx_q.valid && tx_q.data == HOST_ADDR
            && status_q == STATUS_OK;
    endproperty
    a_status_ok: assert property (p_status_ok)
        else $error("reply start or status wrong");

    property p_echo;
        state_q == ST_SEND && tx_q.valid && idx_q == INSTR_BYTE_IDX
        |-> tx_q.data == cmd_q.instr;
    endproperty
    a_echo: assert property (p_echo)
        else $error("instruction not echoed");

    property p_bad_csum;
        state_q == ST_RECV && rx_beat.valid && idx_q == LAST_BYTE_IDX
            && rx_beat.data != sum_q
        |=> state_q == ST_RECV && !tx_q.valid;
    endproperty
    a_bad_csum: assert property (p_bad_csum)
        else $error("bad checksum frame executed");

endmodule

`default_nettype wire

/* File: dv/host_frame_model.sv */
`default_nettype none
module host_frame_model (
    // Clock and pacing
    input  wire logic                         ref_clk,
    input  wire logic                         slow,
    // Command bytes out, reply bytes in
    output var arith_cmd_pkg::byte_beat_type  rx_beat,
    output var logic                          tx_ready,
    input  wire arith_cmd_pkg::byte_beat_type tx_beat
);
    timeunit 1ns;
    timeprecision 1ps;
    import arith_cmd_pkg::*;
    // Quiet until a frame is sent
    initial begin
        rx_beat  = '0;
        tx_ready = 1'b0;
    end
    // Nine bytes, value MSB first; skew spoils the sum on purpose
    task automatic send_frame(input cmd_frame_type f, input logic [7:0] skew);
        logic [7:0] sum;
        logic [7:0] b;
        sum = SUM_INIT;
        for (int k = 0; k < 9; k++) begin
            b = (k < 8) ? f[63-8*k -: 8] : sum + skew;
            sum = sum + b;
            @(posedge ref_clk);
            rx_beat <= '{valid: 1'b1, data: b};
            if (slow) begin
                @(posedge ref_clk);
                rx_beat <= '{valid: 1'b0, data: ~b};
            end
        end
        // Idle data inverted so a stale byte never reads as fresh
        @(posedge ref_clk);
        rx_beat <= '{valid: 1'b0, data: ~b};
    endtask
    // Slow pacing drops ready every other cycle; the wait is bounded
    task automatic get_reply(output logic [71:0] r, output bit got);
        int n;
        n = 0;
        r = '0;
        for (int c = 0; c < 60 && n < 9; c++) begin
            @(posedge ref_clk);
            if (tx_beat.valid === 1'b1 && tx_ready === 1'b1) begin
                r = {r[63:0], tx_beat.data};
                n++;
            end
            tx_ready <= (n < 9) && !(slow && tx_ready);
        end
        got = (n == 9);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_variable_register_arith_cmds.sv */
`default_nettype none
module test_variable_register_arith_cmds;
    timeunit 1ns;
    timeprecision 1ps;
    import arith_cmd_pkg::*;
    // Command, then target and operand it leaves when started from c and 5
    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  op;
        logic [31:0] et;
        logic [31:0] eo;
    } row_type;
    row_type rows [28] = '{
        {8'h2a, 8'h00, 32'h11, 32'h5}, {8'h2a, 8'h01, 32'h7, 32'h5},
        {8'h2a, 8'h02, 32'h3c, 32'h5}, {8'h2a, 8'h03, 32'h2, 32'h5},
        {8'h2a, 8'h04, 32'h2, 32'h5}, {8'h2a, 8'h05, 32'h4, 32'h5},
        {8'h2a, 8'h06, 32'hd, 32'h5}, {8'h2a, 8'h07, 32'h9, 32'h5},
        {8'h2a, 8'h08, 32'hfffffffa, 32'h5}, {8'h2a, 8'h09, 32'h5, 32'h5},
        {8'h2a, 8'h0a, 32'h5, 32'hc}, {8'h2a, 8'h0b, 32'hc, 32'h5},
        {8'h2b, 8'h00, 32'h11, 32'h5}, {8'h2b, 8'h01, 32'h7, 32'h5},
        {8'h2b, 8'h02, 32'h3c, 32'h5}, {8'h2b, 8'h03, 32'h2, 32'h5},
        {8'h2b, 8'h04, 32'h2, 32'h5}, {8'h2b, 8'h05, 32'h4, 32'h5},
        {8'h2b, 8'h06, 32'hd, 32'h5}, {8'h2b, 8'h07, 32'h9, 32'h5},
        {8'h2b, 8'h08, 32'hfffffffa, 32'h5}, {8'h2b, 8'h09, 32'h5, 32'h5},
        {8'h2b, 8'h0a, 32'h5, 32'hc}, {8'h2b, 8'h0b, 32'hc, 32'h5},
        {8'h29, 8'h01, 32'h7, 32'h5}, {8'h29, 8'h09, 32'h5, 32'h5},
        {8'h29, 8'h0a, 32'h5, 32'hc}, {8'h29, 8'h08, 32'hfffffffa, 32'h5}
    };
    logic          ref_clk, reset_n, slow, ld, tx_ready;
    byte_beat_type rx_beat, tx_beat;
    cmp_flags_type cmp_flags;
    logic [31:0]   acc_value, xreg_value, var_peek_data;
    logic [31:0]   acc_load_data, xreg_load_data, var_load_data;
    logic [7:0]    var_load_index, var_peek_index, idx;
    int            bad_count, cmp_count;
    // Block under test; one strobe drives all three side loads
    variable_register_arith_cmds i_variable_register_arith_cmds (
        .ref_clk(ref_clk), .reset_n(reset_n), .rx_beat(rx_beat),
        .tx_ready(tx_ready), .tx_beat(tx_beat), .acc_value(acc_value),
        .xreg_value(xreg_value), .cmp_flags(cmp_flags),
        .acc_load_en(ld), .acc_load_data(acc_load_data),
        .xreg_load_en(ld), .xreg_load_data(xreg_load_data),
        .var_load_en(ld), .var_load_index(var_load_index),
        .var_load_data(var_load_data), .var_peek_index(var_peek_index),
        .var_peek_data(var_peek_data));
    // Host side of the byte streams
    host_frame_model i_host_frame_model (.ref_clk(ref_clk), .slow(slow),
        .rx_beat(rx_beat), .tx_ready(tx_ready), .tx_beat(tx_beat));
    // 50 MHz clock
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    // Case equality so an unknown never passes
    task automatic cmp(input string what, input logic [71:0] exp,
                       input logic [71:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Side loads land together, well before the command executes
    task automatic preload(input logic [31:0] a, x, v, input logic [7:0] i);
        @(posedge ref_clk);
        ld             <= 1'b1;
        acc_load_data  <= a;
        xreg_load_data <= x;
        var_load_data  <= v;
        var_load_index <= i;
        @(posedge ref_clk);
        ld <= 1'b0;
    endtask
    // A good frame must answer in full, a refused one stay silent
    task automatic run_cmd(input logic [7:0] instr, op, i, st, addr, skew);
        logic [71:0]   r;
        logic [71:0]   e;
        bit            got;
        cmd_frame_type f;
        f = {addr, instr, op, i, 32'ha55ac33c};
        i_host_frame_model.send_frame(f, skew);
        i_host_frame_model.get_reply(r, got);
        e = {DEF_HOST_ADDR, DEF_MODULE_ADDR, st, instr, 40'h0};
        e[7:0] = DEF_HOST_ADDR + DEF_MODULE_ADDR + st + instr;
        if (addr == DEF_MODULE_ADDR && skew == 8'h00) begin
            cmp("reply", e, r);
            if (!got) summarize();
        end else begin
            cmp("silence", 72'h0, {71'h0, got});
        end
    endtask
    // Peek takes one edge, so allow two before comparing
    task automatic check_state(input logic [31:0] a, x, v,
                               input logic [1:0] f, input logic [7:0] i);
        @(posedge ref_clk);
        var_peek_index <= i;
        repeat (2) @(posedge ref_clk);
        cmp("acc", {40'h0, a}, {40'h0, acc_value});
        cmp("xreg", {40'h0, x}, {40'h0, xreg_value});
        cmp("var", {40'h0, v}, {40'h0, var_peek_data});
        cmp("flags", {70'h0, f}, {70'h0, cmp_flags});
    endtask
    // The register not involved holds 77 and must keep it
    task automatic do_row(input row_type r, input logic [7:0] i,
                          input logic [31:0] t = 32'hc, o = 32'h5,
                          input logic [1:0] f = 2'h0);
        logic ia;
        logic ix;
        ia = (r.instr == ACC_FROM_VAR_CALC);
        ix = (r.instr == VAR_FROM_XREG_CALC);
        preload(ia ? t : ix ? 32'h77 : o, ix ? o : 32'h77, ia ? o : t, i);
        run_cmd(r.instr, r.op, i, STATUS_OK, DEF_MODULE_ADDR, 8'h00);
        check_state(ia ? r.et : ix ? 32'h77 : r.eo, ix ? r.eo : 32'h77,
                    ia ? r.eo : r.et, f, i);
    endtask
    // Verdict and end of run
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, table walk with alternating pacing, then odd cases
    initial begin
        {reset_n, slow, ld} = '0;
        {acc_load_data, xreg_load_data, var_load_data} = '0;
        {var_load_index, var_peek_index} = '0;
        {bad_count, cmp_count} = '0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (rows[k]) begin
            slow <= k[0];
            idx = 8'hff - 8'(k);
            do_row(rows[k], idx);
        end
        // Signed divide at variable 0, then both compare outcomes
        slow <= 1'b0;
        do_row({8'h2a, 8'h03, 32'hfffffffd, 32'h2}, 8'h00,
               32'hfffffff9, 32'h2);
        do_row({8'h2b, 8'h0b, 32'h3, 32'h7}, 8'h80, 32'h3, 32'h7,
               2'h1);
        do_row({8'h29, 8'h0b, 32'h7, 32'h7}, 8'h40, 32'h7, 32'h7,
               2'h2);
        // Bad sum, foreign address, unknown code, type past the list
        preload(32'h21, 32'h22, 32'h23, 8'h10);
        run_cmd(8'h2a, OP_ADD, 8'h10, STATUS_OK, 8'h01, 8'h01);
        run_cmd(8'h2a, OP_ADD, 8'h10, STATUS_OK, 8'h03, 8'h00);
        run_cmd(8'h28, OP_ADD, 8'h10, STATUS_BAD_INSTR, 8'h01, 8'h00);
        run_cmd(8'h2a, 8'h0c, 8'h10, STATUS_BAD_TYPE, 8'h01, 8'h00);
        check_state(32'h21, 32'h22, 32'h23, 2'h2, 8'h10);
        // Second reset clears state; the next frame still works
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp("acc_rst", 72'h0, {40'h0, acc_value});
        cmp("tx_rst", 72'h0, {63'h0, tx_beat});
        reset_n <= 1'b1;
        do_row({8'h2b, 8'h00, 32'hc, 32'h5}, 8'h00, 32'h7, 32'h5);
        summarize();
    end
endmodule
`default_nettype wire
